/* design/ccdw_pkg.sv */
package ccdw_pkg;
  // Setpoint code width; full scale is the all-ones code
  localparam int CODE_W = 10;
  // Reduced current pulse train: one on-cycle in every eight
  localparam int PWM_PERIOD = 8;
  localparam int PWM_ON = 1;
  // Core clock rate
  localparam int CLK_KHZ = 250000;
  // Slow modulator step time in reduced current mode
  localparam int SLOW_STEP_MS = 40;
  localparam int SLOW_STEP_CYCLES = SLOW_STEP_MS * CLK_KHZ;
  // Watchdog expiry time
  localparam int WDOG_MS = 1000;
  localparam int WDOG_CYCLES = WDOG_MS * CLK_KHZ;
  // Reset values
  localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
  localparam logic TRICKLE_RST = 1'b0;
endpackage

/* design/ccdw_dsm.sv */
`timescale 1ns/10ps
module ccdw_dsm #(
  parameter int CODE_W = 10
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Modulator control
  input  wire logic              step,
  input  wire logic [CODE_W-1:0] code,
  // Switching pattern
  output logic                   bit_out
);
  // Full scale is the all-ones code, so the average is code / full scale
  localparam logic [CODE_W:0] FULL = {1'b0, {CODE_W{1'b1}}};

  typedef struct packed {
    logic [CODE_W:0] acc;
    logic            pulse;
  } ccdw_dsm_t;

  ccdw_dsm_t r;
  ccdw_dsm_t next_r;
  logic [CODE_W:0] sum;

  always_comb begin
    next_r = r;
    sum = r.acc + {1'b0, code};
    if (step) begin
      if (sum >= FULL) begin
        next_r.acc = sum - FULL;
        next_r.pulse = 1'b1;
      end else begin
        next_r.acc = sum;
        next_r.pulse = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign bit_out = r.pulse;

  // Residue stays below full scale, otherwise the average would drift
  AST_DSM_RESIDUE: assert property (@(posedge clk) disable iff (!rst_n) r.acc < FULL)
    else $error("modulator residue reached full scale");
  AST_DSM_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !step |=> $stable(r.acc) && $stable(bit_out))
    else $error("modulator moved without a step");
endmodule

/* design/ccdw_top.sv */
`timescale 1ns/10ps
module ccdw_top #(
  parameter int CODE_W           = ccdw_pkg::CODE_W,
  parameter int PWM_PERIOD       = ccdw_pkg::PWM_PERIOD,
  parameter int PWM_ON           = ccdw_pkg::PWM_ON,
  parameter int SLOW_STEP_CYCLES = ccdw_pkg::SLOW_STEP_CYCLES,
  parameter int WDOG_CYCLES      = ccdw_pkg::WDOG_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Setpoint write from the serial link
  input  wire logic              setpoint_wr,
  input  wire logic [CODE_W-1:0] setpoint_code,
  input  wire logic              slow_trickle_select,
  // Charger control write from the serial link
  input  wire logic              ctl_wr,
  input  wire logic              first_pack_charge_request,
  input  wire logic              second_pack_charge_request,
  // Pack voltage comparators against the minimum charge voltage
  input  wire logic              first_pack_above_min,
  input  wire logic              second_pack_above_min,
  // Converter switch and charge path control
  output logic                   setpoint_switch,
  output logic                   charge_enable,
  output logic                   first_pack_charge_en,
  output logic                   second_pack_charge_en,
  output logic                   feedback_from_second_pack,
  // Status
  output logic                   trickle_mode,
  output logic                   watchdog_alive
);
  localparam int PWM_W  = $clog2(PWM_PERIOD);
  localparam int SLOW_W = $clog2(SLOW_STEP_CYCLES);
  localparam int WDOG_W = $clog2(WDOG_CYCLES);
  localparam logic [PWM_W-1:0]  PWM_ON_CNT = PWM_W'(PWM_ON);
  localparam logic [SLOW_W-1:0] SLOW_LAST  = SLOW_W'(SLOW_STEP_CYCLES - 1);
  localparam logic [WDOG_W-1:0] WDOG_LAST  = WDOG_W'(WDOG_CYCLES - 1);

  // The pulse counter wraps by overflow, so the period must be a power of two
  if (PWM_PERIOD < 2 || (1 << PWM_W) != PWM_PERIOD || PWM_ON < 1 || PWM_ON >= PWM_PERIOD) begin
    $error("unsupported pulse train period or duty");
  end
  if (SLOW_STEP_CYCLES < 2 || WDOG_CYCLES < 4 || CODE_W < 2) begin
    $error("unsupported step, watchdog or code width");
  end

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic              trickle;
    logic              req1;
    logic              req2;
    logic              alive;
    logic [WDOG_W-1:0] wdog_cnt;
    logic [SLOW_W-1:0] slow_cnt;
    logic [PWM_W-1:0]  pwm_cnt;
    logic              sw;
    logic              chg;
    logic              en1;
    logic              en2;
    logic              fb2;
  } ccdw_state_t;

  ccdw_state_t r;
  ccdw_state_t next_r;
  logic        step;
  logic        dsm_bit;
  logic        charging;
  logic        dual;

  // Normal mode steps every cycle; reduced mode waits for the slow tick
  assign step = r.trickle ? (r.slow_cnt == SLOW_LAST) : 1'b1;
  assign charging = r.alive && (r.req1 || r.req2);
  assign dual = r.req1 && r.req2;

  ccdw_dsm #(
    .CODE_W (CODE_W)
  ) u_dsm (
    .clk     (clk),
    .rst_n   (rst_n),
    .step    (step),
    .code    (r.code),
    .bit_out (dsm_bit)
  );

  always_comb begin
    next_r = r;
    if (setpoint_wr) begin
      next_r.code = setpoint_code;
      next_r.trickle = slow_trickle_select;
    end
    next_r.pwm_cnt = r.pwm_cnt + 1'b1;
    if (!r.trickle || r.slow_cnt == SLOW_LAST) begin
      next_r.slow_cnt = '0;
    end else begin
      next_r.slow_cnt = r.slow_cnt + 1'b1;
    end
    // A write wins over expiry in the same cycle
    if (ctl_wr) begin
      next_r.wdog_cnt = '0;
      next_r.alive = 1'b1;
      next_r.req1 = first_pack_charge_request;
      next_r.req2 = second_pack_charge_request;
    end else if (r.alive) begin
      if (r.wdog_cnt == WDOG_LAST) begin
        next_r.alive = 1'b0;
      end else begin
        next_r.wdog_cnt = r.wdog_cnt + 1'b1;
      end
    end
    if (!charging) begin
      next_r.en1 = 1'b0;
      next_r.en2 = 1'b0;
    end else if (r.trickle) begin
      // No voltage check here so a pack with an open protection switch can recover
      next_r.en1 = r.req1;
      next_r.en2 = r.req2 && !r.req1;
    end else if (dual) begin
      next_r.en1 = first_pack_above_min;
      next_r.en2 = second_pack_above_min;
    end else begin
      next_r.en1 = r.req1;
      next_r.en2 = r.req2;
    end
    next_r.chg = next_r.en1 || next_r.en2;
    next_r.fb2 = next_r.en2;
    // Modulator bit gates the short pulse, so the average is one eighth of the modulator duty
    if (r.trickle) begin
      next_r.sw = dsm_bit && (r.pwm_cnt < PWM_ON_CNT);
    end else begin
      next_r.sw = dsm_bit;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.code <= ccdw_pkg::CODE_RST;
      r.trickle <= ccdw_pkg::TRICKLE_RST;
    end else begin
      r <= next_r;
    end
  end

  assign setpoint_switch = r.sw;
  assign charge_enable = r.chg;
  assign first_pack_charge_en = r.en1;
  assign second_pack_charge_en = r.en2;
  assign feedback_from_second_pack = r.fb2;
  assign trickle_mode = r.trickle;
  assign watchdog_alive = r.alive;

  sequence s_single_write;
    ctl_wr && (first_pack_charge_request ^ second_pack_charge_request) ##1 !ctl_wr;
  endsequence
  sequence s_last_tick;
    r.alive && r.wdog_cnt == WDOG_LAST && !ctl_wr;
  endsequence
  sequence s_trickle_pulse;
    r.trickle && $past(r.trickle, 2) && setpoint_switch;
  endsequence

  AST_WRITE_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    setpoint_wr |=> trickle_mode == $past(slow_trickle_select))
    else $error("trickle mode not taken from the write");
  AST_START: assert property (@(posedge clk) disable iff (!rst_n)
    s_single_write |=> charge_enable)
    else $error("charging did not start after a pack request");
  AST_EXPIRE: assert property (@(posedge clk) disable iff (!rst_n)
    s_last_tick |=> !watchdog_alive ##1 !charge_enable)
    else $error("watchdog expiry did not stop charging");
  AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
    ctl_wr |=> watchdog_alive && r.wdog_cnt == '0)
    else $error("control write did not restart the watchdog");
  AST_PULSE_DUTY: assert property (@(posedge clk) disable iff (!rst_n || setpoint_wr)
    s_trickle_pulse |=> !setpoint_switch [*7])
    else $error("reduced mode pulse longer than one eighth");
  AST_SLOW_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    r.trickle && $past(r.trickle) && $changed(dsm_bit) |-> $past(r.slow_cnt) == SLOW_LAST)
    else $error("modulator stepped early in reduced mode");
  AST_NO_DUAL_TRICKLE: assert property (@(posedge clk) disable iff (!rst_n)
    $past(r.trickle) && $past(charging) |-> !(first_pack_charge_en && second_pack_charge_en))
    else $error("dual charging in reduced mode");
  AST_TRICKLE_NO_MIN: assert property (@(posedge clk) disable iff (!rst_n)
    $past(r.trickle && charging && r.req1) |-> first_pack_charge_en)
    else $error("reduced mode blocked the first pack");
  AST_DUAL_MIN: assert property (@(posedge clk) disable iff (!rst_n)
    $past(!r.trickle && charging && dual) |-> first_pack_charge_en == $past(first_pack_above_min)
      && second_pack_charge_en == $past(second_pack_above_min))
    else $error("dual charge of a pack below minimum voltage");
  AST_DUAL_FEEDBACK: assert property (@(posedge clk) disable iff (!rst_n)
    $past(!r.trickle && charging && dual && second_pack_above_min) |-> feedback_from_second_pack)
    else $error("dual charging without second pack feedback");
  // A stopped charger drops every charge path enable, whatever the request bits still say
  AST_STOPPED_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    $past(!charging) |-> !charge_enable && !first_pack_charge_en && !second_pack_charge_en)
    else $error("charge switch left on while stopped");
  AST_TRICKLE_FIRST_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
    $past(r.trickle && charging && dual) |-> first_pack_charge_en && !second_pack_charge_en)
    else $error("second pack charged with both requested in reduced mode");
  AST_NORMAL_PATTERN: assert property (@(posedge clk) disable iff (!rst_n)
    $past(!r.trickle) |-> setpoint_switch == $past(dsm_bit))
    else $error("switch does not follow the modulator in normal mode");
  // Checked slot by slot, so a drifting pulse counter shows up at once
  AST_TRICKLE_PHASE: assert property (@(posedge clk) disable iff (!rst_n)
    $past(r.trickle) && $past(r.pwm_cnt) >= PWM_ON_CNT |-> !setpoint_switch)
    else $error("reduced mode pulse outside its on slot");
endmodule

/* testbench/ccdw_host.sv */
`timescale 1ns/10ps
// Host side of the serial link: one-cycle write strobes with their data
module ccdw_host (
  // Clock
  input  wire logic                        clk,
  // Setpoint word
  output logic                             setpoint_wr,
  output logic [ccdw_pkg::CODE_W-1:0]      setpoint_code,
  output logic                             slow_trickle_select,
  // Charger control word
  output logic                             ctl_wr,
  output logic                             first_pack_charge_request,
  output logic                             second_pack_charge_request
);
  initial begin
    setpoint_wr = 1'b0;
    setpoint_code = 10'h000;
    slow_trickle_select = 1'b0;
    ctl_wr = 1'b0;
    first_pack_charge_request = 1'b0;
    second_pack_charge_request = 1'b0;
  end
  // Data is inverted once the strobe drops, so a stale word is never reused
  task automatic write_setpoint(input logic [ccdw_pkg::CODE_W-1:0] c, input logic t);
    @(posedge clk);
    setpoint_wr <= 1'b1;
    setpoint_code <= c;
    slow_trickle_select <= t;
    @(posedge clk);
    setpoint_wr <= 1'b0;
    setpoint_code <= ~c;
    slow_trickle_select <= ~t;
  endtask
  // Callers refresh once just inside the watchdog time, then let it expire
  task automatic write_ctl(input logic r1, input logic r2);
    @(posedge clk);
    ctl_wr <= 1'b1;
    first_pack_charge_request <= r1;
    second_pack_charge_request <= r2;
    @(posedge clk);
    ctl_wr <= 1'b0;
    first_pack_charge_request <= ~r1;
    second_pack_charge_request <= ~r2;
  endtask
endmodule

/* testbench/test_charge_current_dac_watchdog.sv */
`timescale 1ns/10ps
module test_charge_current_dac_watchdog;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic first_pack_above_min = 1'b0;
  logic second_pack_above_min = 1'b0;
  logic setpoint_wr, slow_trickle_select, ctl_wr;
  logic first_pack_charge_request, second_pack_charge_request;
  logic [ccdw_pkg::CODE_W-1:0] setpoint_code;
  logic setpoint_switch, charge_enable, first_pack_charge_en, second_pack_charge_en;
  logic feedback_from_second_pack, trickle_mode, watchdog_alive;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  logic [9:0] codes [3] = '{10'h000, 10'h200, 10'h3FF};

  always #2 clk = ~clk;

  ccdw_host host (.clk, .setpoint_wr, .setpoint_code, .slow_trickle_select, .ctl_wr,
    .first_pack_charge_request, .second_pack_charge_request);

  // Short counts keep the run brief; expectations below follow them
  ccdw_top #(.SLOW_STEP_CYCLES(16), .WDOG_CYCLES(64)) dut (.clk, .rst_n, .setpoint_wr,
    .setpoint_code, .slow_trickle_select, .ctl_wr, .first_pack_charge_request,
    .second_pack_charge_request, .first_pack_above_min, .second_pack_above_min,
    .setpoint_switch, .charge_enable, .first_pack_charge_en, .second_pack_charge_en,
    .feedback_from_second_pack, .trickle_mode, .watchdog_alive);

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic near(input int c, input int e, input int t);
    check("switch high count", 16'(c >= e - t && c <= e + t), 16'h0001);
  endtask

  task automatic count_high(input int len, output int c);
    c = 0;
    repeat (len) begin
      @(posedge clk);
      #1 c += int'(setpoint_switch);
    end
  endtask

  task automatic ctl(input logic r1, r2, m1, m2, e1, e2);
    @(posedge clk);
    first_pack_above_min <= m1;
    second_pack_above_min <= m2;
    host.write_ctl(r1, r2);
    repeat (2) @(posedge clk);
    #1 check("first_pack_charge_en", first_pack_charge_en, e1);
    check("second_pack_charge_en", second_pack_charge_en, e2);
    check("charge_enable", charge_enable, e1 | e2);
    check("feedback_from_second_pack", feedback_from_second_pack, e2);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Run is about 7350 cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    check("alive in reset", watchdog_alive, 1'b0);
    rst_n <= 1'b1;
    foreach (codes[i]) begin
      host.write_setpoint(codes[i], 1'b0);
      repeat (2) @(posedge clk);
      #1 check("trickle_mode", trickle_mode, 1'b0);
      count_high(1023, n);
      near(n, int'(codes[i]), 1);
    end
    ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    ctl(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (50) @(posedge clk);
    ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (56) @(posedge clk);
    #1 check("alive after refresh", watchdog_alive, 1'b1);
    repeat (12) @(posedge clk);
    #1 check("alive after expiry", watchdog_alive, 1'b0);
    check("charge_enable after expiry", charge_enable, 1'b0);
    host.write_setpoint(10'h3FF, 1'b1);
    repeat (2) @(posedge clk);
    #1 check("trickle_mode", trickle_mode, 1'b1);
    ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    count_high(2048, n);
    near(n, 256, 4);
    host.write_setpoint(10'h200, 1'b1);
    count_high(2048, n);
    near(n, 128, 8);
    report_and_stop();
  end
endmodule
